// ===== rtl/clkgen_map.svh
/*
 * register map, field positions, reset values and timing counts
 * of the clock source and main multiplier loop block.
 * assumes: included by bare name; definitions only.
 */
`ifndef CLKGEN_MAP_SVH
`define CLKGEN_MAP_SVH

// ****************************************
// register byte offsets
// ****************************************
`define OFS_SRC_SEL   8'h00
`define OFS_PLL_CTRL  8'h04
`define OFS_PLL_CFG   8'h08
`define OFS_PLL_STAT  8'h0C
`define OFS_CPU_DIV   8'h10
`define OFS_USB_DIV   8'h14
`define OFS_PERI_SEL  8'h18
`define OFS_WDT_SEL   8'h1C
`define OFS_IRC_TRIM  8'h20

// ****************************************
// field positions
// ****************************************
`define BIT_PLL_EN    0
`define BIT_PLL_CONN  1
`define BIT_ST_LOCK   2
`define BIT_ST_USED   3
`define CFG_N_LSB     16

// ****************************************
// reset values
// ****************************************
`define RST_DIV8      8'h00
`define RST_N         8'h00
`define RST_M         15'h0000
`define RST_TRIM      6'h20
`define RST_CCO_PER   16'h0010

// ****************************************
// nominal figures and timing counts
// ****************************************
`define IRC_FREQ_HZ   4000000
`define LOCK_GOOD     8'h08
`define SW_TMO        16'h1000
`endif

// ===== rtl/clkgen_pkg.sv
/*
 * types shared by the clock generation files.
 * assumes: compiled before every module that imports it.
 */
package clkgen_pkg;
	// clock source feeding the multiplier loop
	typedef enum logic [1:0]
	{
		SRC_IRC  = 2'h0,
		SRC_MAIN = 2'h1,
		SRC_RTC  = 2'h2
	} src_e;
	// watchdog clock source
	typedef enum logic [1:0]
	{
		WDT_IRC  = 2'h0,
		WDT_RTC  = 2'h1,
		WDT_PERI = 2'h2
	} wdt_src_e;
endpackage

// ===== rtl/tick_sync.sv
/*
 * brings an oscillator pin into pclk as one-cycle rising-edge ticks.
 * assumes: pin toggles slower than a quarter of pclk.
 */
module tick_sync
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// pin side
	input wire logic pin,
	// pclk side
	output logic tick
);
	logic s1_reg; // first stage, read by s2 only
	logic s2_reg;
	logic s3_reg;
	logic lvl_reg; // accepted level
	logic lvl_next;
	logic tick_next;

	// ****************************************
	// accept a change once stages two and three agree
	// ****************************************
	always_comb
	begin
		lvl_next = lvl_reg;
		tick_next = 1'b0;
		if (s2_reg == s3_reg && s3_reg != lvl_reg)
		begin
			lvl_next = s3_reg;
			tick_next = s3_reg; // rising edge only
		end
	end

	// registers only
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
			lvl_reg <= 1'b0;
			tick <= 1'b0;
		end
		else
		begin
			s1_reg <= pin;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			lvl_reg <= lvl_next;
			tick <= tick_next;
		end
	end
endmodule

// ===== rtl/tick_divider.sv
/*
 * divides a tick stream by div_val+1; output is registered.
 * assumes: restart realigns the count to a whole output period.
 */
module tick_divider #(
	parameter int W = 8
)
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic restart,
	input wire logic [W-1:0] div_val,
	// ticks
	input wire logic tick_in,
	output logic tick_out
);
	logic [W-1:0] cnt_reg;
	logic [W-1:0] cnt_next;
	logic out_next;

	// ****************************************
	// count input ticks, emit one per full period
	// ****************************************
	always_comb
	begin
		cnt_next = cnt_reg;
		out_next = 1'b0;
		if (restart)
			cnt_next = '0; // no partial period carried over
		else if (tick_in)
		begin
			if (cnt_reg >= div_val)
			begin
				cnt_next = '0;
				out_next = 1'b1;
			end
			else
				cnt_next = cnt_reg + 1'b1;
		end
	end

	// registers only
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_reg <= '0;
			tick_out <= 1'b0;
		end
		else
		begin
			cnt_reg <= cnt_next;
			tick_out <= out_next;
		end
	end
endmodule

// ===== rtl/clock_source_and_main_pll.sv
/*
 * clock sources, reference select, main multiplier loop model,
 * post dividers and per-peripheral clock enables, APB registers.
 * assumes: oscillators arrive as pins; all clocks leave as
 * one-cycle enables in pclk; power_down_entry from the PMU.
 */
// Decided for this implementation: the APB slave port and the register addresses.
`include "clkgen_map.svh"
module clock_source_and_main_pll
	import clkgen_pkg::*;
#(
	parameter int NPERI = 8,
	parameter logic [15:0] SW_TMO = `SW_TMO
)
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// oscillator pins
	input wire logic irc_osc_pin,
	input wire logic main_osc_pin,
	input wire logic rtc_osc_pin,
	// power management
	input wire logic power_down_entry,
	// clock enables out
	output logic cpu_core_clock_en,
	output logic usb_clk_en,
	output logic [NPERI-1:0] peri_clk_en,
	output logic watchdog_timer_clk_en,
	output logic rtc_clk_en,
	output logic usb_pll_ref_en,
	// oscillator and loop status
	output logic [5:0] irc_trim,
	output logic main_multiplier_loop_locked
);

	// ****************************************
	// oscillator pins into pclk
	// ****************************************
	logic internal_rc_osc; // rc oscillator tick
	logic main_t; // main crystal tick
	logic rtc_t; // rtc oscillator tick
	tick_sync u_irc (.pclk(pclk), .presetn(presetn),
		.pin(irc_osc_pin), .tick(internal_rc_osc));
	tick_sync u_main (.pclk(pclk), .presetn(presetn),
		.pin(main_osc_pin), .tick(main_t));
	tick_sync u_rtc (.pclk(pclk), .presetn(presetn),
		.pin(rtc_osc_pin), .tick(rtc_t));

	// ****************************************
	// software registers
	// ****************************************
	src_e src_sel_reg, src_sel_next; // requested source
	src_e src_cur_reg, src_cur_next; // source in use
	logic en_reg, en_next; // loop enable
	logic conn_reg, conn_next; // loop connect
	logic [7:0] n_reg, n_next; // pre-divider minus one
	logic [14:0] m_reg, m_next; // multiplier minus one
	logic [7:0] cdiv_reg, cdiv_next; // cpu post divider
	logic [7:0] udiv_reg, udiv_next; // usb post divider
	logic [2*NPERI-1:0] psel_reg, psel_next; // 2 bits each
	wdt_src_e wsel_reg, wsel_next; // watchdog source
	logic [5:0] trim_reg, trim_next; // rc trim code
	logic [31:0] rd_reg, rd_next; // read data
	logic wr_acc; // write access phase
	logic hit; // mapped address

	assign wr_acc = psel && penable && pwrite;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit;
	assign prdata = rd_reg;
	assign irc_trim = trim_reg;

	// address decode
	always_comb
	begin
		unique case (paddr)
			`OFS_SRC_SEL, `OFS_PLL_CTRL, `OFS_PLL_CFG,
			`OFS_PLL_STAT, `OFS_CPU_DIV, `OFS_USB_DIV,
			`OFS_PERI_SEL, `OFS_WDT_SEL, `OFS_IRC_TRIM:
				hit = 1'b1;
			default:
				hit = 1'b0;
		endcase
	end

	// ****************************************
	// multiplier loop state
	// ****************************************
	logic ref_t; // selected reference tick
	logic ref_div_t; // reference after pre-divider
	logic [7:0] rcnt_reg, rcnt_next;
	logic [15:0] cper_reg, cper_next; // oscillator period
	logic [15:0] ccnt_reg, ccnt_next;
	logic cco_t; // current_controlled_osc tick
	logic [14:0] fcnt_reg, fcnt_next; // feedback count
	logic fb_t; // feedback tick
	logic [1:0] seen_reg, seen_next; // fb per ref, saturating
	logic [7:0] good_reg, good_next; // good comparisons
	logic lock_reg, lock_next;
	logic use_reg, use_next; // loop drives cpu
	logic [15:0] tmo_reg, tmo_next; // switch wait
	logic want_use;
	logic apply; // switch boundary
	logic cpu_pll_t;
	logic usb_pll_t;
	logic cpu_next;

	// reference select: any of three sources
	always_comb
	begin
		unique case (src_cur_reg)
			SRC_MAIN: ref_t = main_t;
			SRC_RTC: ref_t = rtc_t;
			default: ref_t = internal_rc_osc;
		endcase
	end

	assign want_use = en_reg && conn_reg && lock_reg;
	// switch at a cpu enable pulse, or once tmo_reg reaches SW_TMO
	assign apply = cpu_core_clock_en || (tmo_reg == SW_TMO);
	assign ref_div_t = ref_t && (rcnt_reg >= n_reg);
	assign cco_t = en_reg && (ccnt_reg == 16'h0000);
	assign fb_t = cco_t && (fcnt_reg >= m_reg);
	assign main_multiplier_loop_locked = lock_reg;

	// ****************************************
	// register writes, power-down and read data
	// ****************************************
	always_comb
	begin
		src_sel_next = src_sel_reg;
		en_next = en_reg;
		conn_next = conn_reg;
		n_next = n_reg;
		m_next = m_reg;
		cdiv_next = cdiv_reg;
		udiv_next = udiv_reg;
		psel_next = psel_reg;
		wsel_next = wsel_reg;
		trim_next = trim_reg;
		rd_next = rd_reg;
		if (wr_acc)
		begin
			unique case (paddr)
				`OFS_SRC_SEL:
					if (pwdata[1:0] != 2'h3) // reserved code ignored
						src_sel_next = src_e'(pwdata[1:0]);
				`OFS_PLL_CTRL:
				begin
					en_next = pwdata[`BIT_PLL_EN];
					conn_next = pwdata[`BIT_PLL_CONN];
				end
				`OFS_PLL_CFG:
				begin
					m_next = pwdata[14:0];
					n_next = pwdata[`CFG_N_LSB +: 8];
				end
				`OFS_CPU_DIV: cdiv_next = pwdata[7:0];
				`OFS_USB_DIV: udiv_next = pwdata[7:0];
				`OFS_PERI_SEL: psel_next = pwdata[2*NPERI-1:0];
				`OFS_WDT_SEL:
					if (pwdata[1:0] != 2'h3)
						wsel_next = wdt_src_e'(pwdata[1:0]);
				`OFS_IRC_TRIM: trim_next = pwdata[5:0];
				default: ;
			endcase
		end
		// power-down turns the loop off and bypasses it
		if (power_down_entry)
		begin
			en_next = 1'b0;
			conn_next = 1'b0;
		end
		// read data captured in the setup cycle
		if (psel && !penable && !pwrite)
		begin
			rd_next = 32'h0000_0000;
			unique case (paddr)
				`OFS_SRC_SEL: rd_next[1:0] = src_sel_reg;
				`OFS_PLL_CTRL:
				begin
					rd_next[`BIT_PLL_EN] = en_reg;
					rd_next[`BIT_PLL_CONN] = conn_reg;
				end
				`OFS_PLL_CFG:
				begin
					rd_next[14:0] = m_reg;
					rd_next[`CFG_N_LSB +: 8] = n_reg;
				end
				`OFS_PLL_STAT:
				begin
					rd_next[`BIT_PLL_EN] = en_reg;
					rd_next[`BIT_PLL_CONN] = conn_reg;
					rd_next[`BIT_ST_LOCK] = lock_reg;
					rd_next[`BIT_ST_USED] = use_reg;
					rd_next[5:4] = src_cur_reg;
				end
				`OFS_CPU_DIV: rd_next[7:0] = cdiv_reg;
				`OFS_USB_DIV: rd_next[7:0] = udiv_reg;
				`OFS_PERI_SEL: rd_next[2*NPERI-1:0] = psel_reg;
				`OFS_WDT_SEL: rd_next[1:0] = wsel_reg;
				`OFS_IRC_TRIM: rd_next[5:0] = trim_reg;
				default: ;
			endcase
		end
	end

	// ****************************************
	// loop model: pre-divide, oscillator, feedback, detector
	// ****************************************
	always_comb
	begin
		rcnt_next = rcnt_reg;
		ccnt_next = ccnt_reg;
		cper_next = cper_reg;
		fcnt_next = fcnt_reg;
		seen_next = seen_reg;
		good_next = good_reg;
		lock_next = lock_reg;
		if (!en_reg)
		begin
			// powered off: idle and unlocked
			rcnt_next = `RST_N;
			ccnt_next = `RST_CCO_PER;
			cper_next = `RST_CCO_PER;
			fcnt_next = `RST_M;
			seen_next = 2'h0;
			good_next = 8'h00;
			lock_next = 1'b0;
		end
		else
		begin
			// pre-divider by n+1
			if (ref_t)
				rcnt_next = ref_div_t ? 8'h00 : rcnt_reg + 8'h01;
			// oscillator from its period
			ccnt_next = cco_t ? cper_reg : ccnt_reg - 16'h0001;
			// feedback divider by m+1
			if (cco_t)
				fcnt_next = fb_t ? 15'h0000 : fcnt_reg + 15'h0001;
			if (fb_t && seen_reg != 2'h2)
				seen_next = seen_reg + 2'h1;
			// detector: one feedback per reference is right
			if (ref_div_t)
			begin
				seen_next = {1'b0, fb_t};
				if (seen_reg == 2'h1)
				begin
					if (good_reg != `LOCK_GOOD)
						good_next = good_reg + 8'h01;
					else
						lock_next = 1'b1;
				end
				else
				begin
					good_next = 8'h00;
					lock_next = 1'b0;
					if (seen_reg == 2'h0 && cper_reg != 16'h0000)
						cper_next = cper_reg - 16'h0001; // too slow
					else if (seen_reg == 2'h2 && cper_reg != 16'hFFFF)
						cper_next = cper_reg + 16'h0001; // too fast
				end
			end
		end
	end

	// ****************************************
	// glitch-free source and connect switching
	// ****************************************
	always_comb
	begin
		src_cur_next = src_cur_reg;
		use_next = use_reg;
		tmo_next = 16'h0000;
		if (src_sel_reg != src_cur_reg || want_use != use_reg)
		begin
			tmo_next = tmo_reg + 16'h0001;
			if (apply)
			begin
				src_cur_next = src_sel_reg;
				use_next = want_use;
				tmo_next = 16'h0000;
			end
		end
		// losing enable or lock drops the loop at once
		if (!want_use)
			use_next = 1'b0;
		// bypassed: cpu equals reference
		cpu_next = use_reg ? cpu_pll_t : ref_t;
	end

	// post dividers of the oscillator
	tick_divider #(.W(8)) u_cdiv (.pclk(pclk), .presetn(presetn),
		.restart(!use_reg), .div_val(cdiv_reg), .tick_in(cco_t),
		.tick_out(cpu_pll_t));
	tick_divider #(.W(8)) u_udiv (.pclk(pclk), .presetn(presetn),
		.restart(!en_reg), .div_val(udiv_reg), .tick_in(cco_t),
		.tick_out(usb_pll_t));

	// per-peripheral divide by 1, 2, 4 or 8 of cpu clock
	genvar gi;
	generate
		for (gi = 0; gi < NPERI; gi++)
		begin : g_peri
			logic [2:0] dv;
			always_comb
			begin
				unique case (psel_reg[2*gi +: 2])
					2'h0: dv = 3'h0;
					2'h1: dv = 3'h1;
					2'h2: dv = 3'h3;
					default: dv = 3'h7;
				endcase
			end
			tick_divider #(.W(3)) u_pdiv (.pclk(pclk),
				.presetn(presetn), .restart(1'b0), .div_val(dv),
				.tick_in(cpu_core_clock_en), .tick_out(peri_clk_en[gi]));
		end
	endgenerate

	// ****************************************
	// state registers
	// ****************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			src_sel_reg <= SRC_IRC;
			src_cur_reg <= SRC_IRC;
			en_reg <= 1'b0;
			conn_reg <= 1'b0;
			n_reg <= `RST_N;
			m_reg <= `RST_M;
			cdiv_reg <= `RST_DIV8;
			udiv_reg <= `RST_DIV8;
			psel_reg <= '0;
			wsel_reg <= WDT_IRC;
			trim_reg <= `RST_TRIM;
			rd_reg <= 32'h0000_0000;
			rcnt_reg <= `RST_N;
			ccnt_reg <= `RST_CCO_PER;
			cper_reg <= `RST_CCO_PER;
			fcnt_reg <= `RST_M;
			seen_reg <= 2'h0;
			good_reg <= 8'h00;
			lock_reg <= 1'b0;
			use_reg <= 1'b0;
			tmo_reg <= 16'h0000;
			cpu_core_clock_en <= 1'b0;
			usb_clk_en <= 1'b0;
			watchdog_timer_clk_en <= 1'b0;
			rtc_clk_en <= 1'b0;
			usb_pll_ref_en <= 1'b0;
		end
		else
		begin
			src_sel_reg <= src_sel_next;
			src_cur_reg <= src_cur_next;
			en_reg <= en_next;
			conn_reg <= conn_next;
			n_reg <= n_next;
			m_reg <= m_next;
			cdiv_reg <= cdiv_next;
			udiv_reg <= udiv_next;
			psel_reg <= psel_next;
			wsel_reg <= wsel_next;
			trim_reg <= trim_next;
			rd_reg <= rd_next;
			rcnt_reg <= rcnt_next;
			ccnt_reg <= ccnt_next;
			cper_reg <= cper_next;
			fcnt_reg <= fcnt_next;
			seen_reg <= seen_next;
			good_reg <= good_next;
			lock_reg <= lock_next;
			use_reg <= use_next;
			tmo_reg <= tmo_next;
			cpu_core_clock_en <= cpu_next;
			usb_clk_en <= usb_pll_t;
			// watchdog clock: rc, rtc or peripheral
			watchdog_timer_clk_en <= (wsel_reg == WDT_RTC) ? rtc_t :
				(wsel_reg == WDT_PERI) ? peri_clk_en[0] :
				internal_rc_osc;
			rtc_clk_en <= rtc_t;
			usb_pll_ref_en <= main_t;
		end
	end
endmodule

// ===== verif/clkgen_sva.sv
/*
 * port checker for the clock source and multiplier loop block.
 * assumes: bound to the top module; one pclk domain.
 */
module clkgen_sva
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// pins and outputs
	input wire logic main_osc_pin,
	input wire logic rtc_osc_pin,
	input wire logic cpu_core_clock_en,
	input wire logic rtc_clk_en,
	input wire logic usb_pll_ref_en,
	input wire logic [5:0] irc_trim,
	input wire logic main_multiplier_loop_locked
);
	// ****************************************
	// properties
	// ****************************************
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// slave never stalls
	pready_high_a: assert property (pready)
		else $error("pready low");
	// error only in access phase
	slverr_phase_a: assert property (pslverr |-> psel && penable)
		else $error("pslverr outside access");
	// mapped word gives no error
	mapped_ok_a: assert property (psel && penable && paddr <= 8'h20
		&& paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("error on mapped word");
	// access above 0x20 gives error; such a read gives zero
	unmapped_err_a: assert property (psel && penable && paddr > 8'h20
		|-> pslverr && (pwrite || prdata == 32'h0000_0000))
		else $error("unmapped access wrong");
	cpu_pulse_a: assert property (
		cpu_core_clock_en |=> !cpu_core_clock_en)
		else $error("cpu enable wider than one cycle");
	rtc_follow_a: assert property (
		$rose(rtc_osc_pin) |-> ##[2:6] rtc_clk_en)
		else $error("rtc tick missing");
	ref_follow_a: assert property (
		$rose(main_osc_pin) |-> ##[2:6] usb_pll_ref_en)
		else $error("usb reference tick missing");
	trim_reset_a: assert property (
		$rose(presetn) |-> irc_trim == 6'h20)
		else $error("trim not at reset value");
	lock_reset_a: assert property (
		$rose(presetn) |-> !main_multiplier_loop_locked
		##1 !main_multiplier_loop_locked)
		else $error("loop locked after reset");
	// main scenarios seen
	cover property (main_multiplier_loop_locked);
	cover property (pslverr);
	cover property (rtc_clk_en);
endmodule

bind clock_source_and_main_pll clkgen_sva u_sva (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.main_osc_pin(main_osc_pin), .rtc_osc_pin(rtc_osc_pin),
	.cpu_core_clock_en(cpu_core_clock_en), .rtc_clk_en(rtc_clk_en),
	.usb_pll_ref_en(usb_pll_ref_en), .irc_trim(irc_trim),
	.main_multiplier_loop_locked(main_multiplier_loop_locked));

// ===== verif/tb_top.sv
/*
 * self-checking bench: apb register tasks and pulse counting.
 * assumes: oscillator pins made from a free counter in pclk.
 */
`include "clkgen_map.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// signals
	// ****************************************
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready, pslverr, power_down_entry = 1'b0;
	logic [4:0] osc_cnt = 5'h00; // pins /8 /16 /32
	logic cpu_core_clock_en, usb_clk_en, watchdog_timer_clk_en;
	logic rtc_clk_en, usb_pll_ref_en, main_multiplier_loop_locked;
	logic [7:0] peri_clk_en;
	logic [5:0] irc_trim;
	logic [31:0] rd_q;
	logic rd_e;
	int error_cnt = 0, comparisons = 0, cycles = 0;
	int n_cpu, n_per, n_wdt, n_ref, n_usb;
	int wexp[3] = '{64, 16, 64};

	clock_source_and_main_pll #(.SW_TMO(16'h0010)) dut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irc_osc_pin(osc_cnt[2]),
		.main_osc_pin(osc_cnt[3]), .rtc_osc_pin(osc_cnt[4]),
		.power_down_entry(power_down_entry),
		.cpu_core_clock_en(cpu_core_clock_en), .usb_clk_en(usb_clk_en),
		.peri_clk_en(peri_clk_en),
		.watchdog_timer_clk_en(watchdog_timer_clk_en),
		.rtc_clk_en(rtc_clk_en), .usb_pll_ref_en(usb_pll_ref_en),
		.irc_trim(irc_trim),
		.main_multiplier_loop_locked(main_multiplier_loop_locked));

	// clock, oscillators and hang guard
	always #10 pclk = ~pclk;
	always @(posedge pclk)
	begin
		osc_cnt <= osc_cnt + 5'h01;
		cycles <= cycles + 1;
		if (cycles == 40000)
		begin
			error_cnt++;
			finish_test();
		end
	end

	// ****************************************
	// tasks
	// ****************************************
	task automatic finish_test();
		$display("comparisons %0d errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// pulse counts may slip by a few at window edges
	task automatic near(input string nm, input int e, input int g);
		comparisons++;
		if (g < e - 4 || g > e + 4)
		begin
			error_cnt++;
			$display("[ERR] %s expected %0d seen %0d", nm, e, g);
		end
	endtask
	// one apb transfer; answer taken at the edge where pready is high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// wait ends at the first edge with pready high; the hang guard catches a stall
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		rd_q = prdata;
		rd_e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input string nm, input logic [7:0] a,
		input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, e, rd_q);
	endtask
	// count enable pulses over 512 cycles after a settle time
	task automatic win();
		repeat (64) @(negedge pclk);
		n_cpu = 0;
		n_per = 0;
		n_wdt = 0;
		n_ref = 0;
		n_usb = 0;
		repeat (512)
		begin
			@(negedge pclk);
			n_cpu += int'(cpu_core_clock_en === 1'b1);
			n_per += int'(peri_clk_en[2] === 1'b1);
			n_wdt += int'(watchdog_timer_clk_en === 1'b1);
			n_ref += int'(usb_pll_ref_en === 1'b1);
			n_usb += int'(usb_clk_en === 1'b1);
		end
	endtask

	// ****************************************
	// sequence
	// ****************************************
	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rd("src sel", `OFS_SRC_SEL, 32'h0000_0000);
		rd("loop ctrl", `OFS_PLL_CTRL, 32'h0000_0000);
		rd("loop stat", `OFS_PLL_STAT, 32'h0000_0000);
		rd("trim reg", `OFS_IRC_TRIM, 32'h0000_0020);
		chk("trim pin", 32'h0000_0020, {26'h0, irc_trim});
		win();
		near("cpu from rc", 64, n_cpu);
		near("usb ref", 32, n_ref);
		apb(1'b0, 8'h40, 32'h0000_0000);
		chk("unmapped err", 32'h0000_0001, {31'h0, rd_e});
		chk("unmapped data", 32'h0000_0000, rd_q);
		$display("test reset done");
		for (int s = 2; s >= 0; s--)
		begin
			apb(1'b1, `OFS_SRC_SEL, 32'(s));
			win();
			rd("src used", `OFS_PLL_STAT, 32'(s) << 4);
			near("cpu from src", 64 >> s, n_cpu);
		end
		apb(1'b1, `OFS_SRC_SEL, 32'h0000_0003);
		rd("src kept", `OFS_SRC_SEL, 32'h0000_0000);
		for (int k = 0; k < 4; k++)
		begin
			apb(1'b1, `OFS_PERI_SEL, 32'(k) << 4);
			win();
			near("peri clock", 64 >> k, n_per);
		end
		for (int w = 0; w < 3; w++)
		begin
			apb(1'b1, `OFS_WDT_SEL, 32'(w));
			win();
			near("wdt clock", wexp[w], n_wdt);
		end
		$display("test sources done");
		apb(1'b1, `OFS_PLL_CFG, 32'h0000_0001);
		apb(1'b1, `OFS_PLL_CTRL, 32'h0000_0001);
		rd("enabled only", `OFS_PLL_STAT, 32'h0000_0001);
		for (int i = 0; i < 300 && rd_q[2] !== 1'b1; i++)
			apb(1'b0, `OFS_PLL_STAT, 32'h0000_0000);
		chk("lock", 32'h0000_0005, rd_q);
		chk("lock pin", 32'h0000_0001,
			{31'h0, main_multiplier_loop_locked});
		apb(1'b1, `OFS_PLL_CTRL, 32'h0000_0003);
		win();
		rd("loop used", `OFS_PLL_STAT, 32'h0000_000F);
		near("cpu from loop", 128, n_cpu);
		near("usb from loop", 128, n_usb);
		apb(1'b1, `OFS_CPU_DIV, 32'h0000_0001);
		rd("cpu div", `OFS_CPU_DIV, 32'h0000_0001);
		win();
		near("cpu post div", 64, n_cpu);
		near("usb post div", 128, n_usb);
		@(posedge pclk);
		power_down_entry <= 1'b1;
		@(posedge pclk);
		power_down_entry <= 1'b0;
		win();
		apb(1'b0, `OFS_PLL_STAT, 32'h0000_0000);
		chk("power down", 32'h0000_0000, rd_q & 32'h0000_000B);
		near("cpu bypass", 64, n_cpu);
		near("usb off", 0, n_usb);
		$display("test loop done");
		finish_test();
	end
endmodule
